// ### hdl/sinc_defines.svh
// constants of the sinc decimation filter: offsets, fields, reset values, counts
`ifndef SINC_DEFINES_SVH
`define SINC_DEFINES_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define SINC_WORD_W      32
`define SINC_CNT_W       11
`define SINC_ADR_W       8

// ----------------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define SINC_IDX_SETUP   6'h00
`define SINC_IDX_STATUS  6'h01
`define SINC_IDX_DATA    6'h02

// ----------------------------------------------------------------------------
// setup register layout and reset value
// ----------------------------------------------------------------------------
`define SINC_SETUP_RESET 9'h004
`define SINC_CFG_MASK    9'h0FC
`define SINC_LANE0_HI    7
`define SINC_LANE1_BIT   8
`define SINC_SETUP_HI    8
`define SINC_STATUS_PAD  28'h0000000
`define SINC_RDATA_PAD   23'h000000
`define SINC_ZERO_WORD   32'h00000000
`define SINC_ONE_WORD    32'h00000001

// ----------------------------------------------------------------------------
// decimation factors per notch setting, divided by the multiplier
// ----------------------------------------------------------------------------
`define SINC_N_FS0       11'h600
`define SINC_N_FS1       11'h500
`define SINC_N_FS2       11'h100
`define SINC_N_FS3       11'h080
`define SINC_CNT_ONE     11'h001
`define SINC_CNT_ZERO    11'h000

// ----------------------------------------------------------------------------
// settling, in output words
// ----------------------------------------------------------------------------
`define SINC_SETTLE_SINC3 2'h3
`define SINC_SETTLE_SINC1 2'h1
`define SINC_SETTLE_ONE   2'h1
`define SINC_SETTLE_ZERO  2'h0

`endif

// ### hdl/sinc_pkg.sv
// types shared by the sinc decimation filter modules
package sinc_pkg;
  `include "sinc_defines.svh"

  typedef logic [`SINC_WORD_W-1:0] word_t;
  typedef logic [`SINC_CNT_W-1:0]  cnt_t;

  // setup register, msb first: bit 8 down to bit 0
  typedef struct packed {
    logic filter_sync_hold;
    logic notch_select_hi;
    logic notch_select_lo;
    logic rate_multiplier_hi;
    logic rate_multiplier_lo;
    logic input_halving_enable;
    logic master_rate_high;
    logic modulator_bypass;
    logic fast_select;
  } setup_t;

  // whole state of the filter core
  typedef struct packed {
    setup_t     setup;
    logic       ack;
    word_t      rdata;
    logic       presc;
    logic       tick;
    cnt_t       dec_cnt;
    word_t      int1;
    word_t      int2;
    word_t      int3;
    word_t      result;
    logic [1:0] settle;
    logic       settled;
    logic       valid;
    logic       serial;
  } core_t;

  // state of one comb stage
  typedef struct packed {
    word_t delay;
  } comb_state_t;
endpackage

// ### hdl/comb_if.sv
// carrier between the filter core and one comb stage
`timescale 1ns/1ps
interface comb_if;
  import sinc_pkg::*;
  logic  load;
  logic  clear;
  word_t din;
  word_t dout;
  modport stage (input load, input clear, input din, output dout);
  modport feed  (output load, output clear, output din, input dout);
endinterface

// ### hdl/comb_stage.sv
// one differentiator stage of the decimator, run at the output word rate
`timescale 1ns/1ps
`include "sinc_defines.svh"
module comb_stage (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  // stage signals
  comb_if.stage       port_c
);
  import sinc_pkg::*;

  comb_state_t st_reg;
  comb_state_t st_next;

  // ----------------------------------------------------------------------------
  // difference against the word one period back
  // ----------------------------------------------------------------------------
  // modular subtraction is exact as long as the word holds n cubed
  assign port_c.dout = port_c.din - st_reg.delay;

  // next delay value
  always_comb begin
    st_next = st_reg;
    if (port_c.clear) begin
      st_next.delay = `SINC_ZERO_WORD;
    end else if (port_c.load) begin
      st_next.delay = port_c.din;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_delay_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    port_c.load && !port_c.clear |=> st_reg.delay == $past(port_c.din))
    else $error("comb delay did not take the stage input");
endmodule

// ### hdl/sinc_decimation_filter.sv
// sinc1 / sinc3 decimation filter with classic wishbone register slave
// What this block does
// - filter and decimate the 1-bit stream, one word per period, sinc1 or sinc3
// - in sinc1 mode the result is settled after a single word period
// - fast select set gives sinc1, cleared gives the default sinc3
// - leaving sinc1 for sinc3 drops valid; it returns after three periods
// - bypass set sends the raw modulator bits straight to serial out
// - sinc3 is three cascaded moving sums of n samples
// - one output word per n modulator bits
// - output word rate equals first notch, notches at its multiples
// - sinc3 cutoff is a fixed fraction of the first notch
// - notch attenuation beyond 100dB, so arithmetic keeps full precision
// - rate, prescaler, multiplier and notch bits jointly set the rate
// - notch bits only scale the notches, response shape unchanged
// - synchronised start gives a settled sinc3 word after three periods
// - master rate bit selects low or high master clock, high at reset
// - prescaler enable halves the incoming clock for the internal clock
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sinc_defines.svh"
module sinc_decimation_filter (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // wishbone slave
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [7:0]            i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire sinc_pkg::word_t       i_wb_dat,
  output logic                       o_wb_ack,
  output sinc_pkg::word_t            o_wb_dat,
  // modulator side
  input  wire logic                  i_mod_bit,
  output logic                       o_sample_strobe,
  output logic                       o_master_rate_high,
  // result side
  output sinc_pkg::word_t            o_result,
  output logic                       o_result_valid,
  output logic                       o_serial_data
);
  import sinc_pkg::*;

  // ----------------------------------------------------------------------------
  // state and comb chain
  // ----------------------------------------------------------------------------
  core_t  st_reg;
  core_t  st_next;
  comb_if cif[4] ();

  // decoded request and derived terms
  logic   req;
  logic   wr_setup;
  logic   rd_data;
  setup_t wr_value;
  logic   restart;
  logic   last;
  cnt_t   n_base;
  cnt_t   n_cur;
  cnt_t   n_last;
  logic [1:0] settle_inc;
  logic [1:0] settle_need;
  logic   word_settled;
  word_t  sample;

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  // ack stays low for a cycle between requests, so each access is taken once
  assign req      = i_wb_cyc && i_wb_stb && !st_reg.ack;
  assign wr_setup = req && i_wb_we && (i_wb_adr[7:2] == `SINC_IDX_SETUP);
  assign rd_data  = req && !i_wb_we && (i_wb_adr[7:2] == `SINC_IDX_DATA);

  // byte-lane merge of a setup write
  always_comb begin
    wr_value = st_reg.setup;
    if (i_wb_sel[0]) begin
      wr_value[`SINC_LANE0_HI:0] = i_wb_dat[`SINC_LANE0_HI:0];
    end
    if (i_wb_sel[1]) begin
      wr_value[`SINC_LANE1_BIT] = i_wb_dat[`SINC_LANE1_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // decimation factor
  // ----------------------------------------------------------------------------
  // the notch bits pick n, the multiplier divides it; the same boxcar shape
  // is kept, so cutoff and notch depth track the word rate
  always_comb begin
    case ({st_reg.setup.notch_select_hi, st_reg.setup.notch_select_lo})
      2'h0:    n_base = `SINC_N_FS0;
      2'h1:    n_base = `SINC_N_FS1;
      2'h2:    n_base = `SINC_N_FS2;
      2'h3:    n_base = `SINC_N_FS3;
      default: n_base = `SINC_N_FS0;
    endcase
  end

  assign n_cur  = n_base >> {st_reg.setup.rate_multiplier_hi,
                             st_reg.setup.rate_multiplier_lo};
  assign n_last = n_cur - `SINC_CNT_ONE;
  // word boundary: first notch lands on the output word rate
  assign last   = st_reg.tick && (st_reg.dec_cnt == n_last);

  // ----------------------------------------------------------------------------
  // restart of settling
  // ----------------------------------------------------------------------------
  // clearing the whole chain makes the first words start from a known state,
  // which is what a synchronised start relies on
  assign restart = (wr_setup && (((wr_value ^ st_reg.setup) & `SINC_CFG_MASK) != '0))
                || (wr_setup && st_reg.setup.fast_select && !wr_value.fast_select)
                || st_reg.setup.filter_sync_hold;

  assign settle_need = st_reg.setup.fast_select ? `SINC_SETTLE_SINC1
                                                : `SINC_SETTLE_SINC3;
  assign settle_inc  = (st_reg.settle == `SINC_SETTLE_SINC3) ? st_reg.settle
                     : st_reg.settle + `SINC_SETTLE_ONE;
  assign word_settled = last && !restart && (settle_inc >= settle_need);
  assign sample = i_mod_bit ? `SINC_ONE_WORD : `SINC_ZERO_WORD;

  // ----------------------------------------------------------------------------
  // comb chain hookup: three stages for sinc3, one stage on the first sum
  // ----------------------------------------------------------------------------
  assign cif[0].din = st_reg.int3;
  assign cif[1].din = cif[0].dout;
  assign cif[2].din = cif[1].dout;
  assign cif[3].din = st_reg.int1;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_comb
      assign cif[gi].load  = last;
      assign cif[gi].clear = restart;
      comb_stage u_comb (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .port_c   (cif[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // bus answer one cycle after the request
    st_next.ack = req;
    if (req) begin
      case (i_wb_adr[7:2])
        `SINC_IDX_SETUP:  st_next.rdata = {`SINC_RDATA_PAD, st_reg.setup};
        `SINC_IDX_STATUS: st_next.rdata = {`SINC_STATUS_PAD, st_reg.settle,
                                           st_reg.settled, st_reg.valid};
        `SINC_IDX_DATA:   st_next.rdata = st_reg.result;
        default:          st_next.rdata = `SINC_ZERO_WORD;
      endcase
    end
    if (wr_setup) begin
      st_next.setup = wr_value;
    end

    // internal clock tick, halved when the prescaler is on
    st_next.presc = st_reg.setup.input_halving_enable ? !st_reg.presc : 1'b0;
    st_next.tick  = st_reg.setup.input_halving_enable ? !st_reg.presc : 1'b1;

    // raw modulator bits straight out while bypassed
    if (st_reg.tick) begin
      st_next.serial = st_reg.setup.modulator_bypass && i_mod_bit;
    end

    // integrators: modular sums, exact for n cubed inside 32 bits
    if (st_reg.tick) begin
      st_next.int1 = st_reg.int1 + sample;
      st_next.int2 = st_reg.int2 + st_reg.int1;
      st_next.int3 = st_reg.int3 + st_reg.int2;
      st_next.dec_cnt = last ? `SINC_CNT_ZERO : st_reg.dec_cnt + `SINC_CNT_ONE;
    end

    // one word per period, sinc1 or sinc3 as selected
    if (last) begin
      st_next.result = st_reg.setup.fast_select ? cif[3].dout : cif[2].dout;
      st_next.settle = settle_inc;
    end
    if (word_settled) begin
      st_next.settled = 1'b1;
    end

    // valid: a new settled word wins over a read that clears it
    if (word_settled) begin
      st_next.valid = 1'b1;
    end else if (rd_data) begin
      st_next.valid = 1'b0;
    end

    // restart drops sums, counter, settle count and flags back to the unsettled start; the result word is not cleared, and still loads on a coinciding word boundary
    if (restart) begin
      // the sample taken at a restart edge with a tick opens the first window, so
      // word one holds a full n samples; a restart edge without a tick gives n - 1
      st_next.int1    = st_reg.tick ? sample : `SINC_ZERO_WORD;
      st_next.int2    = `SINC_ZERO_WORD;
      st_next.int3    = `SINC_ZERO_WORD;
      st_next.dec_cnt = `SINC_CNT_ZERO;
      st_next.settle  = `SINC_SETTLE_ZERO;
      st_next.settled = 1'b0;
      st_next.valid   = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg       <= '0;
      st_reg.setup <= `SINC_SETUP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs, all straight from the state register
  assign o_wb_ack           = st_reg.ack;
  assign o_wb_dat           = st_reg.rdata;
  assign o_sample_strobe    = st_reg.tick;
  assign o_master_rate_high = st_reg.setup.master_rate_high;
  assign o_result           = st_reg.result;
  assign o_result_valid     = st_reg.valid;
  assign o_serial_data      = st_reg.serial;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence seq_cfg_write;
    wr_setup && (((wr_value ^ st_reg.setup) & `SINC_CFG_MASK) != '0);
  endsequence

  sequence seq_fast_exit;
    wr_setup && st_reg.setup.fast_select && !wr_value.fast_select;
  endsequence

  sequence seq_data_read;
    rd_data && !word_settled;
  endsequence

  chk_bypass_stream: assert property (
    st_reg.tick && st_reg.setup.modulator_bypass |=> o_serial_data == $past(i_mod_bit))
    else $error("bypass did not pass the modulator bit");

  chk_word_count: assert property (
    st_reg.tick && !last && !restart |=> st_reg.dec_cnt == $past(st_reg.dec_cnt) + 1)
    else $error("decimation counter did not advance");

  chk_cfg_restart: assert property (
    seq_cfg_write |=> !o_result_valid && st_reg.settle == `SINC_SETTLE_ZERO)
    else $error("rate change did not restart settling");

  chk_fast_exit: assert property (
    seq_fast_exit |=> !o_result_valid ##1 !o_result_valid[*2])
    else $error("valid not dropped on leaving sinc1");

  chk_sinc3_settle: assert property (
    $rose(st_reg.settled) && !st_reg.setup.fast_select |-> st_reg.settle == `SINC_SETTLE_SINC3)
    else $error("sinc3 settled before three words");

  chk_sinc1_settle: assert property (
    last && !restart && st_reg.setup.fast_select |=> o_result_valid && st_reg.settled)
    else $error("sinc1 word not valid after one period");

  chk_ack_single: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  chk_halving_tick: assert property (
    st_reg.setup.input_halving_enable && $past(st_reg.setup.input_halving_enable)
    && st_reg.tick |=> !st_reg.tick)
    else $error("prescaler did not halve the tick");

  chk_read_clear: assert property (
    seq_data_read ##1 !restart |-> !o_result_valid)
    else $error("data read did not clear valid");

  // ----------------------------------------------------------------------------
  // checks on the bus answer and the stream timing
  // ----------------------------------------------------------------------------
  sequence seq_bus_request;
    req;
  endsequence

  sequence seq_setup_take;
    wr_setup;
  endsequence

  chk_bus_answer: assert property (
    seq_bus_request |=> o_wb_ack)
    else $error("bus request not answered in the next cycle");

  chk_setup_take: assert property (
    seq_setup_take |=> st_reg.setup == $past(wr_value))
    else $error("setup write did not land");

  chk_unmapped_zero: assert property (
    req && !i_wb_we && (i_wb_adr[7:2] > `SINC_IDX_DATA) |=> o_wb_dat == `SINC_ZERO_WORD)
    else $error("unmapped read did not return zero");

  chk_data_read: assert property (
    rd_data |=> o_wb_dat == $past(st_reg.result))
    else $error("data read did not return the last word");

  // hold keeps the chain cleared, so a released hold starts a clean window
  chk_hold_clear: assert property (
    st_reg.setup.filter_sync_hold |=> !o_result_valid && st_reg.dec_cnt == `SINC_CNT_ZERO)
    else $error("sync hold did not keep the chain cleared");

  chk_serial_quiet: assert property (
    st_reg.tick && !st_reg.setup.modulator_bypass |=> !o_serial_data)
    else $error("serial output active without bypass");

  chk_full_tick: assert property (
    !st_reg.setup.input_halving_enable |=> st_reg.tick)
    else $error("sample tick missing with prescaler off");

  chk_count_wrap: assert property (
    last |=> st_reg.dec_cnt == `SINC_CNT_ZERO)
    else $error("decimation counter did not wrap at the word");

  chk_result_hold: assert property (
    !last |=> $stable(o_result))
    else $error("result changed between words");

  // valid never stands on a word that the selected response has not settled
  chk_valid_settled: assert property (
    o_result_valid |-> st_reg.settled)
    else $error("valid without a settled word");

  chk_sinc3_valid: assert property (
    o_result_valid && !st_reg.setup.fast_select |-> st_reg.settle == `SINC_SETTLE_SINC3)
    else $error("sinc3 word flagged before three periods");
endmodule

// ### testbench/mod_source.sv
// stand-in for the modulator that feeds the decimation filter
`timescale 1ns/1ps
module mod_source (
  // clock and stream control
  input  wire logic       i_clk,
  input  wire logic       i_strobe,
  input  wire logic [1:0] i_pattern,
  // modulator bit
  output logic            o_bit
);
  logic toggle_reg;

  // next bit only after the filter took one, so a slow strobe sees each bit once
  initial toggle_reg = 1'b0;
  always @(posedge i_clk) begin
    if (i_strobe) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // pattern 0 zeros, 1 ones, 2 alternating; alternating keeps any even window at half scale
  assign o_bit = (i_pattern == 2'h2) ? toggle_reg : i_pattern[0];
endmodule

// ### testbench/testbench.sv
// self-checking bench of the sinc decimation filter
`timescale 1ns/1ps
module testbench;
  import sinc_pkg::*;
  typedef struct packed {
    logic       fast;
    logic [1:0] pat;
    logic [1:0] notch;
    logic [1:0] mf;
    int         n;
    word_t      exp;
  } row_t;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       wb_cyc = 1'b0;
  logic       wb_stb = 1'b0;
  logic       wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  word_t      wb_dat = 32'h00000000;
  logic       wb_ack;
  word_t      wb_rdat;
  logic       mod_bit;
  logic       strobe;
  logic       rate_high;
  word_t      result;
  logic       valid;
  logic       serial;
  logic [1:0] pattern = 2'h1;
  int         errors = 0;
  int         checks = 0;
  int         k;
  word_t      q;
  word_t      d;
  row_t       rows [8];

  sinc_decimation_filter sinc_decimation_filter_i (
    .i_clk(clk), .i_resetn(resetn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_ack(wb_ack),
    .o_wb_dat(wb_rdat), .i_mod_bit(mod_bit), .o_sample_strobe(strobe),
    .o_master_rate_high(rate_high), .o_result(result), .o_result_valid(valid),
    .o_serial_data(serial));
  mod_source mod_source_i (.i_clk(clk), .i_strobe(strobe), .i_pattern(pattern), .o_bit(mod_bit));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_word(input word_t got, input word_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle: request held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input word_t wd, output word_t rd);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat <= wd;
    // no cycle count is assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  // cycles from the end of the last access until the flag rises, bounded
  task automatic wait_valid(output int n);
    n = 0;
    while (valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
  endtask

  // a stuck handshake or flag must not hang the run
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    // fast, pattern, notch, multiplier, n, expected settled word
    rows[0] = '{1'b1, 2'h1, 2'h3, 2'h3, 16, 32'h00000010};
    rows[1] = '{1'b0, 2'h1, 2'h3, 2'h3, 16, 32'h00001000};
    rows[2] = '{1'b0, 2'h2, 2'h2, 2'h3, 32, 32'h00004000};
    rows[3] = '{1'b1, 2'h2, 2'h1, 2'h3, 160, 32'h00000050};
    rows[4] = '{1'b0, 2'h0, 2'h0, 2'h3, 192, 32'h00000000};
    rows[5] = '{1'b0, 2'h1, 2'h3, 2'h0, 128, 32'h00200000};
    rows[6] = '{1'b1, 2'h1, 2'h3, 2'h1, 64, 32'h00000040};
    rows[7] = '{1'b1, 2'h2, 2'h3, 2'h2, 32, 32'h00000010};
    do_reset();
    // -----------------------------------------------------------------
    // ordinary cases: synchronised start through the hold bit
    // -----------------------------------------------------------------
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      pattern <= rows[r].pat;
      d = {23'h000000, 1'b1, rows[r].notch, rows[r].mf, 3'b010, rows[r].fast};
      wb(1'b1, 8'h00, d, q);
      wb(1'b1, 8'h00, d & 32'h000000FF, q);
      // data is taken only once flagged, past any settling
      wait_valid(k);
      k = k - (rows[r].fast ? 1 : 3) * rows[r].n;
      cmp_bit(k >= -3 && k <= 3, 1'b1);
      cmp_word(result, rows[r].exp);
      cmp_bit(serial, 1'b0);
      wb(1'b0, 8'h08, 32'h00000000, q);
      cmp_word(q, rows[r].exp);
      wb(1'b0, 8'h04, 32'h00000000, q);
      cmp_bit(q[0], 1'b0);
    end
    // -----------------------------------------------------------------
    // reset in mid-run and register edges
    // -----------------------------------------------------------------
    do_reset();
    @(posedge clk);
    cmp_bit(rate_high, 1'b1);
    cmp_bit(valid, 1'b0);
    wb(1'b0, 8'h00, 32'h00000000, q);
    cmp_word(q, 32'h00000004);
    wb(1'b1, 8'h04, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h04, 32'h00000000, q);
    cmp_word(q, 32'h00000000);
    wb(1'b0, 8'h3C, 32'h00000000, q);
    cmp_word(q, 32'h00000000);
    wb(1'b1, 8'h00, 32'h00000000, q);
    @(posedge clk);
    cmp_bit(rate_high, 1'b0);
    // -----------------------------------------------------------------
    // mode switch and setting change while valid is up
    // -----------------------------------------------------------------
    @(posedge clk);
    pattern <= 2'h1;
    wb(1'b1, 8'h00, 32'h000000F5, q);
    wait_valid(k);
    cmp_bit(k >= 13 && k <= 19, 1'b1);
    wb(1'b1, 8'h00, 32'h000000F4, q);
    wait_valid(k);
    cmp_bit(k >= 45 && k <= 51, 1'b1);
    cmp_word(result, 32'h00001000);
    wb(1'b1, 8'h00, 32'h000000B4, q);
    wait_valid(k);
    cmp_bit(k >= 93 && k <= 99, 1'b1);
    cmp_word(result, 32'h00008000);
    // -----------------------------------------------------------------
    // prescaler halves the sample strobe
    // -----------------------------------------------------------------
    wb(1'b1, 8'h00, 32'h000000FC, q);
    repeat (3) @(posedge clk);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (strobe === 1'b1) k++;
    end
    cmp_bit(k == 20, 1'b1);
    // -----------------------------------------------------------------
    // bypass passes the raw bits to the serial output
    // -----------------------------------------------------------------
    wb(1'b1, 8'h00, 32'h000000F6, q);
    repeat (4) @(posedge clk);
    cmp_bit(serial, 1'b1);
    pattern <= 2'h0;
    repeat (4) @(posedge clk);
    cmp_bit(serial, 1'b0);
    end_sim();
  end
endmodule
